// ==== design/wdrs_pkg.sv ====
// package: register layout, command codes and timing figures of the watchdog and reset cause
package wdrs_pkg;

  localparam logic [7:0] WDOG_CTRL_ADDR = 8'hFF;
  localparam logic [7:0] RST_CAUSE_ADDR = 8'hEF;

  localparam logic [7:0] CMD_ENABLE_RELOAD = 8'hA5;
  localparam logic [7:0] CMD_DISABLE_FIRST = 8'hDE;
  localparam logic [7:0] CMD_DISABLE_SECOND = 8'hAD;
  localparam logic [7:0] CMD_LOCKOUT = 8'hFF;

  localparam int CTRL_UPDATE_BIT = 7;
  localparam int CTRL_ACTIVE_BIT = 4;
  localparam int INTERVAL_LSB = 0;
  localparam int INTERVAL_W = 3;
  localparam logic [2:0] INTERVAL_RESET = 3'h7;

  localparam int CNT_W = 21;
  localparam int TIMEOUT_BASE_EXP = 3;
  localparam logic [2:0] DISABLE_GAP_CLKS = 3'h4;

  localparam int PIN_BIT = 0;
  localparam int POR_BIT = 1;
  localparam int MCD_BIT = 2;
  localparam int WDOG_BIT = 3;
  localparam int SW_BIT = 4;
  localparam int CMP_BIT = 5;
  localparam int CNV_BIT = 6;
  localparam logic [7:0] CAUSE_WRITABLE = 8'h66;
  localparam logic [7:0] CAUSE_RESET = 8'h00;

  localparam int PIN_STRETCH_CLKS = 12;
  localparam logic [3:0] STRETCH_LOAD = 4'hC;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wdrs_sfr_req_t;

  typedef struct packed {
    logic pin;
    logic power_on;
    logic missing_clock;
    logic comparator;
    logic convert_start;
  } wdrs_src_t;

endpackage : wdrs_pkg

// ==== design/wdrs_sync.sv ====
// two-flop synchroniser bank for the asynchronous reset-source inputs
`timescale 1ns/1ps
`default_nettype none
module wdrs_sync #(
  parameter int W = 5
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] stage1;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      stage1 <= '0;
      sync_o <= '0;
    end
    else
    begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule : wdrs_sync
`default_nettype wire

// ==== design/wdrs_top.sv ====
// watchdog control register, watchdog counter and reset cause register
`timescale 1ns/1ps
`default_nettype none
module wdrs_top (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic pin_rst_n_i,
  input wire logic power_on_i,
  input wire logic missing_clock_i,
  input wire logic comparator_low_i,
  input wire logic convert_start_input_i,
  output logic sys_reset_o,
  output logic pin_drive_low_o
);

  // --------------------------------------------------------------
  // request bundling and input synchronisers
  // --------------------------------------------------------------
  wdrs_pkg::wdrs_sfr_req_t req;
  wdrs_pkg::wdrs_src_t src_async;
  wdrs_pkg::wdrs_src_t src;

  always_comb
  begin
    req.wr = sfr_wr_i;
    req.rd = sfr_rd_i;
    req.addr = sfr_addr_i;
    req.wdata = sfr_wdata_i;
    src_async.pin = ~pin_rst_n_i;
    src_async.power_on = power_on_i;
    src_async.missing_clock = missing_clock_i;
    src_async.comparator = comparator_low_i;
    src_async.convert_start = ~convert_start_input_i;
  end

  wdrs_sync #(
    .W($bits(wdrs_pkg::wdrs_src_t))
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .async_i(src_async),
    .sync_o(src)
  );

  // --------------------------------------------------------------
  // register decode
  // --------------------------------------------------------------
  function automatic logic hit(input wdrs_pkg::wdrs_sfr_req_t r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction : hit

  logic ctrl_wr;
  logic cause_wr;
  assign ctrl_wr = hit(req, wdrs_pkg::WDOG_CTRL_ADDR);
  assign cause_wr = hit(req, wdrs_pkg::RST_CAUSE_ADDR);

  // internal reset: sys_reset_o is a registered request, so the watchdog state
  // restarts one cycle after any source fires
  logic int_rst;
  assign int_rst = !rst_n_i || sys_reset_o;

  // --------------------------------------------------------------
  // watchdog control state
  // --------------------------------------------------------------
  logic wd_running;
  logic lockout;
  logic [2:0] interval;
  logic [2:0] gap_cnt;
  logic armed;
  logic [wdrs_pkg::CNT_W-1:0] count;

  // gap counter starts at the first disable code; second code must land within 4 clocks
  always_ff @(posedge clk_sys_i)
  begin
    if (int_rst)
    begin
      armed <= 1'b0;
      gap_cnt <= 3'h0;
    end
    else if (ctrl_wr && req.wdata == wdrs_pkg::CMD_DISABLE_FIRST)
    begin
      armed <= 1'b1;
      gap_cnt <= 3'h0;
    end
    else if (armed)
    begin
      gap_cnt <= gap_cnt + 3'h1;
      if (gap_cnt >= wdrs_pkg::DISABLE_GAP_CLKS - 3'h1 || ctrl_wr)
        armed <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (int_rst)
      lockout <= 1'b0;
    else if (ctrl_wr && req.wdata == wdrs_pkg::CMD_LOCKOUT)
      lockout <= 1'b1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (int_rst)
      wd_running <= 1'b1;
    else if (ctrl_wr && req.wdata == wdrs_pkg::CMD_ENABLE_RELOAD)
      wd_running <= 1'b1;
    else if (ctrl_wr && req.wdata == wdrs_pkg::CMD_DISABLE_SECOND && armed && !lockout)
      wd_running <= 1'b0;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (int_rst)
      interval <= wdrs_pkg::INTERVAL_RESET;
    else if (ctrl_wr && !req.wdata[wdrs_pkg::CTRL_UPDATE_BIT])
      interval <= req.wdata[wdrs_pkg::INTERVAL_LSB +: wdrs_pkg::INTERVAL_W];
  end

  // --------------------------------------------------------------
  // watchdog counter and overflow
  // --------------------------------------------------------------
  // half of the limit 4^(3+sel) = 2^(6+2*sel), that is 2^(5+2*sel)
  function automatic logic [wdrs_pkg::CNT_W-1:0] limit_of(input logic [2:0] sel);
    logic [4:0] sh;
    sh = 5'(2 * (wdrs_pkg::TIMEOUT_BASE_EXP + int'(sel)) - 1);
    limit_of = wdrs_pkg::CNT_W'(1) << sh;
  endfunction : limit_of

  logic overflow;
  // >= so that shrinking the interval mid-count still overflows instead of waiting for a wrap
  assign overflow = wd_running && (count >= limit_of(interval) - wdrs_pkg::CNT_W'(1));

  // the counter runs to half the limit twice; half marks the second lap, whose end fires
  logic half;

  always_ff @(posedge clk_sys_i)
  begin
    if (int_rst || (ctrl_wr && req.wdata == wdrs_pkg::CMD_ENABLE_RELOAD))
    begin
      count <= '0;
      half <= 1'b0;
    end
    else if (wd_running)
    begin
      if (overflow)
      begin
        count <= '0;
        half <= 1'b1;
      end
      else
        count <= count + wdrs_pkg::CNT_W'(1);
    end
  end

  // --------------------------------------------------------------
  // reset generation
  // --------------------------------------------------------------
  logic sw_force;
  logic pin_force;
  logic [7:0] cause;
  logic [3:0] stretch;

  assign sw_force = cause_wr && req.wdata[wdrs_pkg::SW_BIT];
  assign pin_force = cause_wr && req.wdata[wdrs_pkg::PIN_BIT];

  logic wd_fire;
  logic cmp_fire;
  logic cnv_fire;
  logic mcd_fire;
  assign wd_fire = overflow && half;
  assign cmp_fire = cause[wdrs_pkg::CMP_BIT] && src.comparator;
  assign cnv_fire = cause[wdrs_pkg::CNV_BIT] && src.convert_start;
  assign mcd_fire = cause[wdrs_pkg::MCD_BIT] && src.missing_clock;

  logic any_fire;
  assign any_fire = wd_fire || cmp_fire || cnv_fire || mcd_fire || sw_force || pin_force
    || src.pin || src.power_on;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      sys_reset_o <= 1'b0;
    else
      sys_reset_o <= any_fire && !sys_reset_o;
  end

  // software pin reset drives the pin low for a short stretch
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      stretch <= 4'h0;
    else if (pin_force)
      stretch <= wdrs_pkg::STRETCH_LOAD;
    else if (stretch != 4'h0)
      stretch <= stretch - 4'h1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      pin_drive_low_o <= 1'b0;
    else
      pin_drive_low_o <= pin_force || (stretch > 4'h1);
  end

  // --------------------------------------------------------------
  // reset cause register
  // --------------------------------------------------------------
  // flags latch on the reset event; the enable bits double as flags, so a reset from
  // another source disarms them and software must re-arm after such a reset; the source that fired stays armed
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      cause <= wdrs_pkg::CAUSE_RESET;
    else if (any_fire && !sys_reset_o)
    begin
      cause[wdrs_pkg::PIN_BIT] <= src.pin || pin_force;
      cause[wdrs_pkg::POR_BIT] <= src.power_on;
      cause[wdrs_pkg::MCD_BIT] <= mcd_fire;
      cause[wdrs_pkg::WDOG_BIT] <= wd_fire;
      cause[wdrs_pkg::SW_BIT] <= sw_force;
      cause[wdrs_pkg::CMP_BIT] <= cmp_fire;
      cause[wdrs_pkg::CNV_BIT] <= cnv_fire;
      cause[7] <= 1'b0;
    end
    else if (cause_wr)
      cause <= (cause & ~wdrs_pkg::CAUSE_WRITABLE) | (req.wdata & wdrs_pkg::CAUSE_WRITABLE);
  end

  // --------------------------------------------------------------
  // read data
  // --------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb
  begin
    next_rdata = 8'h00;
    if (req.rd && req.addr == wdrs_pkg::WDOG_CTRL_ADDR)
    begin
      next_rdata[wdrs_pkg::CTRL_ACTIVE_BIT] = wd_running;
      next_rdata[wdrs_pkg::INTERVAL_LSB +: wdrs_pkg::INTERVAL_W] = interval;
    end
    else if (req.rd && req.addr == wdrs_pkg::RST_CAUSE_ADDR)
      next_rdata = cause;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      sfr_rdata_o <= 8'h00;
    else
      sfr_rdata_o <= next_rdata;
  end

endmodule : wdrs_top
`default_nettype wire

// ==== tb/wdrs_monitor.sv ====
// checker: port assertions for the watchdog and reset cause registers
`timescale 1ns/1ps
`default_nettype none
module wdrs_monitor (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic sys_reset_o
);
  logic act;
  logic lock;
  logic [2:0] sel;
  logic [2:0] arm;
  logic [21:0] cnt;
  wire cw = sfr_wr_i && sfr_addr_i == 8'hFF;
  // ----
  // shadow of watchdog state
  // ----
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i || sys_reset_o)
    begin
      act <= 1'b1;
      lock <= 1'b0;
      sel <= 3'h7;
      arm <= 3'h0;
      cnt <= 22'h0;
    end
    else
    begin
      arm <= cw ? (sfr_wdata_i == 8'hDE ? 3'h4 : 3'h0) : (arm != 3'h0 ? arm - 3'h1 : 3'h0);
      cnt <= (!act || (cw && sfr_wdata_i == 8'hA5)) ? 22'h0 : cnt + 22'h1;
      if (cw && sfr_wdata_i == 8'hA5)
        act <= 1'b1;
      else if (cw && sfr_wdata_i == 8'hAD && arm != 3'h0 && !lock)
        act <= 1'b0;
      if (cw && sfr_wdata_i == 8'hFF)
        lock <= 1'b1;
      if (cw && !sfr_wdata_i[7])
        sel <= sfr_wdata_i[2:0];
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  rdata_idle_a: assert property (!sfr_rd_i |=> sfr_rdata_o == 8'h00)
    else $error("read data not idle");
  unmapped_rd_a: assert property (sfr_rd_i && sfr_addr_i != 8'hFF && sfr_addr_i != 8'hEF
    |=> sfr_rdata_o == 8'h00) else $error("unmapped read not zero");
  cause_rsvd_a: assert property (sfr_rd_i && sfr_addr_i == 8'hEF |=> !sfr_rdata_o[7])
    else $error("reserved cause bit set");
  status_bit_a: assert property (sfr_rd_i && sfr_addr_i == 8'hFF
    |=> sfr_rdata_o[4] == $past(act)) else $error("status bit wrong");
  interval_rd_a: assert property (sfr_rd_i && sfr_addr_i == 8'hFF
    |=> sfr_rdata_o[2:0] == $past(sel)) else $error("interval readback wrong");
  reset_pulse_a: assert property (sys_reset_o |=> !sys_reset_o)
    else $error("reset request longer than one cycle");
  reload_quiet_a: assert property (cw && sfr_wdata_i == 8'hA5 |=> !sys_reset_o [*8])
    else $error("reset right after reload");
  wdog_bound_a: assert property (cnt <= (22'h1 << (6 + 2 * sel)) + 22'h4)
    else $error("watchdog overran its interval");
  cover property (cw && sfr_wdata_i == 8'hDE ##2 cw && sfr_wdata_i == 8'hAD);
  cover property (lock && cw && sfr_wdata_i == 8'hAD);
  cover property (sys_reset_o);
endmodule : wdrs_monitor
bind wdrs_top wdrs_monitor u_mon (.clk_sys_i, .rst_n_i, .sfr_wr_i, .sfr_rd_i, .sfr_addr_i,
  .sfr_wdata_i, .sfr_rdata_o, .sys_reset_o);
`default_nettype wire

// ==== tb/wdrs_top_tb.sv ====
// testbench: register sequences for the watchdog and reset cause block
`timescale 1ns/1ps
`default_nettype none
module wdrs_top_tb;
  logic clk_sys_i = 1'b0;
  logic rst_n_i, wr, rd, pin_n, sysr, pdl;
  logic [3:0] srcp;
  logic [7:0] addr, wdata, rdata;
  int n_mismatch = 0;
  int checked = 0;
  int n_rst = 0;
  int i, r0;
  wdrs_top dut (.clk_sys_i, .rst_n_i, .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_addr_i(addr),
    .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .pin_rst_n_i(pin_n), .power_on_i(srcp[3]),
    .missing_clock_i(srcp[2]), .comparator_low_i(srcp[1]), .convert_start_input_i(~srcp[0]),
    .sys_reset_o(sysr), .pin_drive_low_o(pdl));
  initial
  begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
    if (sysr === 1'b1)
      n_rst <= n_rst + 1;
  // ----
  // access tasks
  // ----
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // a write leaves one idle cycle, still well inside the disable gap
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask : wreg
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] m,
    input logic [7:0] e);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    chk(nm, rdata & m, e);
    tick(1);
  endtask : rchk
  // write the cause enables, pulse one source for a cycle, count the reset pulses
  task automatic src_rst(input string nm, input logic [7:0] en, input logic [3:0] p,
    input logic [7:0] nr, input logic [7:0] e);
    int r;
    r = n_rst;
    wreg(8'hEF, en);
    srcp = p;
    tick(1);
    srcp = 4'h0;
    tick(6);
    chk(nm, 8'(n_rst - r), nr);
    rchk(nm, 8'hEF, 8'hFF, e);
  endtask : src_rst
  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  initial
  begin
    #200000;
    n_mismatch++;
    final_report();
  end
  initial
  begin
    {wr, rd, addr, wdata, pin_n, rst_n_i} = {18'h0, 1'b1, 1'b0};
    srcp = 4'h0;
    tick(12);
    rst_n_i = 1'b1;
    rchk("ctrl reset", 8'hFF, 8'h17, 8'h17);
    rchk("cause reset", 8'hEF, 8'hFF, 8'h00);
    wreg(8'h10, 8'h00);
    rchk("ctrl untouched", 8'hFF, 8'h07, 8'h07);
    rchk("unmapped", 8'h10, 8'hFF, 8'h00);
    wreg(8'hFF, 8'h01);
    rchk("interval set", 8'hFF, 8'h07, 8'h01);
    wreg(8'hFF, 8'h83);
    rchk("interval kept", 8'hFF, 8'h07, 8'h01);
    wreg(8'hFF, 8'h00);
    wreg(8'hFF, 8'hA5);
    tick(40);
    wreg(8'hFF, 8'hA5);
    for (i = 0; i < 100 && sysr !== 1'b1; i++)
      tick(1);
    // reset comes 4^3 edges after the reload edge; the loop starts one edge later
    chk("overflow", 8'(i), 8'h3F);
    tick(3);
    rchk("wdog cause", 8'hEF, 8'h08, 8'h08);
    rchk("ctrl after wdog", 8'hFF, 8'h17, 8'h17);
    wreg(8'hFF, 8'h00);
    wreg(8'hFF, 8'hDE);
    wreg(8'hFF, 8'hAD);
    rchk("disabled", 8'hFF, 8'h10, 8'h00);
    r0 = n_rst;
    tick(150);
    chk("no overflow", 8'(n_rst - r0), 8'h00);
    wreg(8'hFF, 8'hA5);
    wreg(8'hFF, 8'hDE);
    tick(6);
    wreg(8'hFF, 8'hAD);
    rchk("late second", 8'hFF, 8'h10, 8'h10);
    wreg(8'hFF, 8'hFF);
    wreg(8'hFF, 8'hDE);
    wreg(8'hFF, 8'hAD);
    rchk("locked", 8'hFF, 8'h17, 8'h10);
    rst_n_i = 1'b0;
    tick(2);
    rst_n_i = 1'b1;
    wreg(8'hFF, 8'hDE);
    wreg(8'hFF, 8'hAD);
    rchk("unlocked", 8'hFF, 8'h17, 8'h07);
    pin_n = 1'b0;
    tick(3);
    pin_n = 1'b1;
    tick(30);
    rchk("pin cause", 8'hEF, 8'h01, 8'h01);
    src_rst("sw reset", 8'h10, 4'h0, 8'h01, 8'h10);
    r0 = n_rst;
    addr = 8'hEF;
    wdata = 8'h01;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    chk("pin drive on", {7'h0, pdl}, 8'h01);
    tick(11);
    chk("pin drive held", {7'h0, pdl}, 8'h01);
    tick(1);
    chk("pin drive off", {7'h0, pdl}, 8'h00);
    chk("pin force resets", 8'(n_rst - r0), 8'h01);
    rchk("pin force cause", 8'hEF, 8'hFF, 8'h01);
    src_rst("cmp disarmed", 8'h00, 4'h2, 8'h00, 8'h01);
    src_rst("cmp reset", 8'h20, 4'h2, 8'h01, 8'h20);
    src_rst("mcd reset", 8'h04, 4'h4, 8'h01, 8'h04);
    src_rst("cnv reset", 8'h40, 4'h1, 8'h01, 8'h40);
    src_rst("por reset", 8'h00, 4'h8, 8'h01, 8'h02);
    final_report();
  end
endmodule : wdrs_top_tb
`default_nettype wire
